// ### common/vpa_pkg.sv
// How it works
// - Clause 22 management registers are reachable over the MDIO pins.
// - Negotiation runs only with autoneg_enable; resets and restart events rerun it.
// - Each negotiation sets complete and page received, and registers the result.
// - Common abilities are the AND of advertised and partner bits, best mode wins.
// - No common ability means negotiation fails and parallel detection is used.
// - Advertisement resets with all four ability bits set; software may rewrite them.
// - Advertisement writes after completion change nothing until negotiation reruns.
// - Partner default abilities come from the duplex pin and the two straps.
// - No next page, remote fault or 100BASE-T4 on either side.
// - Duplex pin and straps are static; their changes never restart negotiation.
// - On success the partner-able bit is set and partner abilities are loaded.
// - Fallback clears partner-able, picks half duplex, strap speed, one ability bit.
// - With negotiation off, speed and duplex come from the control bits.
// - With negotiation on, control speed and duplex bits are ignored.
// - Local pause ability is advertised and resolved against the emulated partner.
// - On success, partner pause bits mirror the local pause bits, so requests are granted.
// - Manual flow control applies when negotiation is off or manual select set.
// - Manual flow control register never changes advertised pause bits.
// - MAC mode with negotiation on: full duplex when pin equals polarity strap.
// - In MAC mode the bank does not answer on MDIO, only on the bus.
// - Management side is local; switch fabric port plays the link partner.
// - Reset control bit resets the block and clears itself after 16 clock cycles.
// - vp_soft_reset clears itself and reads 0 once the reset has finished.
package vpa_pkg;

  // Timing
  localparam int CLK_MHZ      = 125;
  localparam int RCTL_RST_US  = 102;
  localparam int RCTL_RST_CYC = RCTL_RST_US * CLK_MHZ;
  localparam int SOFT_RST_CYC = 16;
  localparam int CNT_W        = 16;

  // Register indices, byte address is four times the index
  localparam logic [4:0] IDX_CTRL = 5'h00;
  localparam logic [4:0] IDX_STAT = 5'h01;
  localparam logic [4:0] IDX_ADV  = 5'h04;
  localparam logic [4:0] IDX_LPA  = 5'h05;
  localparam logic [4:0] IDX_EXP  = 5'h06;
  localparam logic [4:0] IDX_MFC  = 5'h10;
  localparam logic [4:0] IDX_RCTL = 5'h11;

  // Field positions
  localparam int CTRL_RST   = 15;
  localparam int CTRL_SPD   = 13;
  localparam int CTRL_AN    = 12;
  localparam int CTRL_RSTAN = 9;
  localparam int CTRL_DUP   = 8;
  localparam int STAT_ANC   = 5;
  localparam int TECH_LSB   = 5;
  localparam int ADV_SYM    = 10;
  localparam int ADV_ASYM   = 11;
  localparam int EXP_LPAN   = 0;
  localparam int EXP_PR     = 1;
  localparam int MFC_RX     = 0;
  localparam int MFC_TX     = 1;
  localparam int MFC_SEL    = 2;
  localparam int RCTL_VRST  = 1;

  // Reset values, masks and MDIO frame counts
  localparam logic [15:0] CTRL_RST_VAL = 16'h3100;
  localparam logic [15:0] CTRL_WMASK   = 16'h3300;
  localparam logic [15:0] ADV_RST_VAL  = 16'h0DE1;
  localparam logic [15:0] ADV_WMASK    = 16'h0DE0;
  localparam logic [15:0] SEL_FIELD    = 16'h0001;
  localparam logic [15:0] STAT_FIXED   = 16'h780D;
  localparam logic [5:0]  PRE_ONES     = 6'h20;
  localparam logic [5:0]  HDR_LAST     = 6'h0B;
  localparam logic [5:0]  DAT_LAST     = 6'h0F;

  // Synchronised pin positions
  localparam int NPIN  = 6;
  localparam int P_MDC = 0;
  localparam int P_MDI = 1;
  localparam int P_DUP = 2;
  localparam int P_POL = 3;
  localparam int P_SPD = 4;
  localparam int P_MAC = 5;

  typedef enum logic [1:0] {AN_WAIT, AN_RESOLVE, AN_PAGE, AN_DONE} vpa_an_t;
  typedef enum logic [2:0] {MI_IDLE, MI_HDR, MI_TA, MI_RDAT, MI_WDAT} vpa_mi_t;

  typedef struct packed {
    vpa_an_t          an;
    logic [15:0]      ctrl;
    logic [15:0]      adv;
    logic [15:0]      lpa;
    logic [1:0]       exp;
    logic [2:0]       mfc;
    logic             anc;
    logic             sr_rc;
    logic             busy;
    logic [CNT_W-1:0] rst_cnt;
    logic             res_spd;
    logic             res_dup;
    logic             res_rx;
    logic             res_tx;
    logic             port_spd;
    logic             port_dup;
    logic             fc_rx;
    logic             fc_tx;
    logic [NPIN-1:0]  s1;
    logic [NPIN-1:0]  s2;
    logic [NPIN-1:0]  s3;
    logic [NPIN-1:0]  pin_st;
    logic             mdc_rise;
    logic             ahb_wr;
    logic             ahb_map;
    logic [4:0]       ahb_idx;
    logic [15:0]      hrd;
  } vpa_st_t;

  typedef struct packed {
    vpa_mi_t     st;
    logic [5:0]  cnt;
    logic [15:0] sh;
    logic        rd_op;
    logic [4:0]  regad;
    logic        mdo;
    logic        oe;
    logic        wr;
  } vpa_mi_st_t;

  // Power-up starts busy, so the straps settle before the first negotiation
  localparam vpa_st_t ST_RST = '{an: AN_WAIT, ctrl: CTRL_RST_VAL, adv: ADV_RST_VAL,
                                 lpa: SEL_FIELD, busy: 1'b1,
                                 rst_cnt: CNT_W'(SOFT_RST_CYC - 1), default: '0};

endpackage : vpa_pkg

// ### common/vpa_mgmt_if.sv
`timescale 1ns/1ps
interface vpa_mgmt_if;
  logic        mdc_rise;
  logic        mdio_bit;
  logic        enable;
  logic        req_wr;
  logic [4:0]  reg_addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        mdio_out;
  logic        mdio_oe;

  modport frm (input mdc_rise, input mdio_bit, input enable, input rdata,
               output req_wr, output reg_addr, output wdata, output mdio_out,
               output mdio_oe);
  modport regs (output mdc_rise, output mdio_bit, output enable, output rdata,
                input req_wr, input reg_addr, input wdata, input mdio_out,
                input mdio_oe);
endinterface : vpa_mgmt_if

// ### rtl/vpa_mdio_frm.sv
`timescale 1ns/1ps
module vpa_mdio_frm #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input wire logic   hclk,
  input wire logic   hresetn,
  vpa_mgmt_if.frm    mi
);

  vpa_pkg::vpa_mi_st_t s;
  vpa_pkg::vpa_mi_st_t n;
  logic                b;

  //////////////////////////////////////////////////////////////////////////
  // Frame walker, one step per management clock rising edge
  always_comb
  begin
    n    = s;
    n.wr = 1'b0;
    b    = mi.mdio_bit;
    if (!mi.enable)
    begin
      n.st = vpa_pkg::MI_IDLE;
      n.oe = 1'b0;
    end
    else if (mi.mdc_rise)
    begin
      n.cnt = s.cnt + 6'h01;
      case (s.st)
        vpa_pkg::MI_IDLE:
        begin
          n.sh = {s.sh[14:0], b};
          if (b && !s.sh[0] && s.cnt >= vpa_pkg::PRE_ONES)
          begin
            n.st  = vpa_pkg::MI_HDR;
            n.cnt = 6'h00;
          end
          else if (b && !s.sh[0])
            n.cnt = 6'h01;
          else if (b && s.cnt >= vpa_pkg::PRE_ONES)
            n.cnt = s.cnt;
          else if (!b)
            n.cnt = s.sh[0] ? s.cnt : 6'h00;
        end
        vpa_pkg::MI_HDR:
        begin
          n.sh = {s.sh[14:0], b};
          if (s.cnt == vpa_pkg::HDR_LAST)
          begin
            n.regad = {s.sh[3:0], b};
            n.cnt   = 6'h00;
            n.rd_op = s.sh[10:9] == 2'h2;
            if (s.sh[8:4] == PHY_ADDR && (s.sh[10:9] == 2'h2 || s.sh[10:9] == 2'h1))
              n.st = vpa_pkg::MI_TA;
            else
            begin
              n.st = vpa_pkg::MI_IDLE;
              n.sh = '0;
            end
          end
        end
        vpa_pkg::MI_TA:
        begin
          if (s.cnt == 6'h00)
          begin
            n.oe  = s.rd_op;
            n.mdo = 1'b0;
          end
          else
          begin
            n.cnt = 6'h00;
            if (s.rd_op)
            begin
              n.mdo = mi.rdata[15];
              n.sh  = {mi.rdata[14:0], 1'b0};
              n.st  = vpa_pkg::MI_RDAT;
            end
            else
              n.st = vpa_pkg::MI_WDAT;
          end
        end
        vpa_pkg::MI_RDAT:
        begin
          if (s.cnt == vpa_pkg::DAT_LAST)
          begin
            n.oe  = 1'b0;
            n.st  = vpa_pkg::MI_IDLE;
            n.sh  = '0;
            n.cnt = 6'h00;
          end
          else
          begin
            n.mdo = s.sh[15];
            n.sh  = {s.sh[14:0], 1'b0};
          end
        end
        vpa_pkg::MI_WDAT:
        begin
          n.sh = {s.sh[14:0], b};
          if (s.cnt == vpa_pkg::DAT_LAST)
          begin
            n.wr  = 1'b1;
            n.st  = vpa_pkg::MI_IDLE;
            n.cnt = 6'h00;
          end
        end
        default: n.st = vpa_pkg::MI_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= '0;
    else
      s <= n;
  end

  // Outputs straight from flops
  assign mi.req_wr   = s.wr;
  assign mi.reg_addr = s.regad;
  assign mi.wdata    = s.sh;
  assign mi.mdio_out = s.mdo;
  assign mi.mdio_oe  = s.oe;

endmodule : vpa_mdio_frm

// ### rtl/vpa_top.sv
`timescale 1ns/1ps
module vpa_top #(
  parameter logic [4:0]  PHY_ADDR     = 5'h00,
  parameter logic [15:0] RCTL_RST_CYC = 16'(vpa_pkg::RCTL_RST_CYC)
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        mdc,
  input  wire logic        mdio_level,
  output logic             mdio_value,
  output logic             mdio_enable,
  input  wire logic        port0_duplex_pin,
  input  wire logic        duplex_polarity_strap,
  input  wire logic        speed_default_strap,
  input  wire logic        mac_mode_pin,
  input  wire logic        digital_soft_reset,
  input  wire logic        eeprom_reload,
  output logic             port_speed_100,
  output logic             port_full_duplex,
  output logic             port_rx_pause_en,
  output logic             port_tx_pause_en
);

  vpa_pkg::vpa_st_t s;
  vpa_pkg::vpa_st_t n;
  logic [5:0]       agree;
  logic             an_en;
  logic             dup_match;
  logic [3:0]       lpa_tech;
  logic [3:0]       common;
  logic [1:0]       best;
  logic             restart;
  logic             manual;

  vpa_mgmt_if mi ();

  //////////////////////////////////////////////////////////////////////////
  // Functions

  // Register read view shared by the bus and the MDIO side
  function automatic logic [15:0] vpa_rd(input vpa_pkg::vpa_st_t r, input logic [4:0] idx);
    logic [15:0] v;
    v = 16'h0000;
    case (idx)
      vpa_pkg::IDX_CTRL: v = r.ctrl;
      vpa_pkg::IDX_STAT: v = vpa_pkg::STAT_FIXED | (16'(r.anc) << vpa_pkg::STAT_ANC);
      vpa_pkg::IDX_ADV:  v = r.adv;
      vpa_pkg::IDX_LPA:  v = r.lpa;
      vpa_pkg::IDX_EXP:  v = {14'h0000, r.exp};
      vpa_pkg::IDX_MFC:  v = {10'h000, r.port_dup, r.fc_tx, r.fc_rx, r.mfc};
      vpa_pkg::IDX_RCTL: v = {14'h0000, r.sr_rc, 1'b0};
      default:           v = 16'h0000;
    endcase
    return v;
  endfunction : vpa_rd

  // Register write shared by the bus and the MDIO side
  function automatic vpa_pkg::vpa_st_t vpa_wr(input vpa_pkg::vpa_st_t r,
                                              input logic [4:0] idx,
                                              input logic [15:0] d);
    vpa_pkg::vpa_st_t w;
    w = r;
    case (idx)
      vpa_pkg::IDX_CTRL:
      begin
        w.ctrl = d & vpa_pkg::CTRL_WMASK;
        w.ctrl[vpa_pkg::CTRL_RST] = d[vpa_pkg::CTRL_RST] | r.ctrl[vpa_pkg::CTRL_RST];
        w.ctrl[vpa_pkg::CTRL_RSTAN] = d[vpa_pkg::CTRL_RSTAN];
      end
      // No next page, remote fault or T4 bits can be set
      vpa_pkg::IDX_ADV:  w.adv = (d & vpa_pkg::ADV_WMASK) | vpa_pkg::SEL_FIELD;
      // Manual settings live apart from the advert
      vpa_pkg::IDX_MFC:  w.mfc = d[2:0];
      vpa_pkg::IDX_RCTL: w.sr_rc = r.sr_rc | d[vpa_pkg::RCTL_VRST];
      default:           w = r;
    endcase
    return w;
  endfunction : vpa_wr

  // Partner default abilities {100F, 100H, 10F, 10H}
  function automatic logic [3:0] vpa_lpa_def(input logic full, input logic spd100);
    return spd100 ? {full, 1'b1, full, 1'b1} : {2'b00, full, 1'b1};
  endfunction : vpa_lpa_def

  // Best common mode as {speed100, full}
  function automatic logic [1:0] vpa_best(input logic [3:0] c);
    logic [1:0] m;
    m = 2'b00;
    if (c[3])
      m = 2'b11;
    else if (c[2])
      m = 2'b10;
    else if (c[1])
      m = 2'b01;
    return m;
  endfunction : vpa_best

  //////////////////////////////////////////////////////////////////////////
  // MDIO frame handler, silent in MAC mode
  assign mi.mdc_rise = s.mdc_rise;
  assign mi.mdio_bit = s.pin_st[vpa_pkg::P_MDI];
  assign mi.enable   = !s.pin_st[vpa_pkg::P_MAC];
  assign mi.rdata    = vpa_rd(s, mi.reg_addr);

  // Clause 22 bank on the management pins
  vpa_mdio_frm #(
    .PHY_ADDR (PHY_ADDR)
  ) u_frm (
    .hclk    (hclk),
    .hresetn (hresetn),
    .mi      (mi.frm)
  );

  //////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    n         = s;
    // Pin synchronisers, a bit moves once stages two and three agree
    n.s1      = {mac_mode_pin, speed_default_strap, duplex_polarity_strap,
                 port0_duplex_pin, mdio_level, mdc};
    n.s2      = s.s1;
    n.s3      = s.s2;
    agree     = ~(s.s2 ^ s.s3);
    n.pin_st  = (s.pin_st & ~agree) | (s.s3 & agree);
    n.mdc_rise = n.pin_st[vpa_pkg::P_MDC] & ~s.pin_st[vpa_pkg::P_MDC];
    an_en     = s.ctrl[vpa_pkg::CTRL_AN];
    dup_match = s.pin_st[vpa_pkg::P_DUP] == s.pin_st[vpa_pkg::P_POL];
    lpa_tech  = vpa_lpa_def(dup_match, s.pin_st[vpa_pkg::P_SPD]);
    common    = s.adv[vpa_pkg::TECH_LSB +: 4] & lpa_tech;
    best      = vpa_best(common);
    restart   = 1'b0;
    manual    = 1'b0;

    // Bus address phase, word writes only, reads of any size
    n.ahb_wr  = hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
    n.ahb_map = haddr[31:7] == 25'h0000000;
    if (hsel && hready && htrans[1])
      n.ahb_idx = haddr[6:2];

    // Register writes from the bus data phase and from MDIO
    if (s.ahb_wr && s.ahb_map)
      n = vpa_wr(n, s.ahb_idx, hwdata[15:0]);
    if (mi.req_wr && mi.reg_addr != vpa_pkg::IDX_RCTL)
      n = vpa_wr(n, mi.reg_addr, mi.wdata);

    // Restart events only, pin changes never rerun it
    if (n.ctrl[vpa_pkg::CTRL_RSTAN] || digital_soft_reset || eeprom_reload)
    begin
      restart = 1'b1;
      n.ctrl[vpa_pkg::CTRL_RSTAN] = 1'b0;
    end

    // Soft resets, self clearing when the count runs out
    if (s.busy && s.rst_cnt == '0)
    begin
      n.busy  = 1'b0;
      n.sr_rc = 1'b0;
      n.ctrl[vpa_pkg::CTRL_RST] = 1'b0;
    end
    else if (n.ctrl[vpa_pkg::CTRL_RST] || n.sr_rc)
    begin
      n.ctrl  = vpa_pkg::CTRL_RST_VAL | (n.ctrl & 16'h8000);
      n.adv   = vpa_pkg::ADV_RST_VAL;
      n.mfc   = 3'h0;
      restart = 1'b1;
      if (!s.busy)
      begin
        n.busy    = 1'b1;
        n.rst_cnt = n.sr_rc ? RCTL_RST_CYC - 16'h0001
                            : 16'(vpa_pkg::SOFT_RST_CYC - 1);
      end
      else
        n.rst_cnt = s.rst_cnt - 16'h0001;
    end
    // Power-up settle, lets the straps pass the synchronisers first
    else if (s.busy)
      n.rst_cnt = s.rst_cnt - 16'h0001;

    // Negotiation sequence
    if (restart)
    begin
      n.an  = vpa_pkg::AN_WAIT;
      n.anc = 1'b0;
      n.exp = 2'b00;
    end
    else
    begin
      case (s.an)
        vpa_pkg::AN_WAIT:
          if (an_en && !s.busy)
            n.an = vpa_pkg::AN_RESOLVE;
        vpa_pkg::AN_RESOLVE:
        begin
          n.an  = vpa_pkg::AN_PAGE;
          n.lpa = vpa_pkg::SEL_FIELD;
          if (|common)
          begin
            // Success, partner mirrors local pause
            n.res_spd = best[1];
            n.res_dup = best[0];
            n.res_rx  = s.adv[vpa_pkg::ADV_SYM];
            n.res_tx  = s.adv[vpa_pkg::ADV_SYM] | s.adv[vpa_pkg::ADV_ASYM];
            n.exp[vpa_pkg::EXP_LPAN] = 1'b1;
            n.lpa[vpa_pkg::TECH_LSB +: 4] = lpa_tech;
            n.lpa[vpa_pkg::ADV_SYM]  = s.adv[vpa_pkg::ADV_SYM];
            n.lpa[vpa_pkg::ADV_ASYM] = s.adv[vpa_pkg::ADV_ASYM];
          end
          else
          begin
            // Parallel detect fallback
            n.res_spd = s.pin_st[vpa_pkg::P_SPD];
            n.res_dup = 1'b0;
            n.res_rx  = 1'b0;
            n.res_tx  = 1'b0;
            n.exp[vpa_pkg::EXP_LPAN] = 1'b0;
            n.lpa[vpa_pkg::TECH_LSB +: 4] = s.pin_st[vpa_pkg::P_SPD] ? 4'h4 : 4'h1;
          end
        end
        vpa_pkg::AN_PAGE:
        begin
          n.exp[vpa_pkg::EXP_PR] = 1'b1;
          n.an = vpa_pkg::AN_DONE;
        end
        vpa_pkg::AN_DONE:
          n.anc = 1'b1;   // Result already held
        default: n.an = vpa_pkg::AN_WAIT;
      endcase
    end

    // Operating mode
    if (!an_en)
    begin
      n.port_spd = s.ctrl[vpa_pkg::CTRL_SPD];
      n.port_dup = s.ctrl[vpa_pkg::CTRL_DUP];
    end
    else
    begin
      n.port_spd = s.res_spd;
      n.port_dup = s.pin_st[vpa_pkg::P_MAC] ? dup_match : s.res_dup;
    end

    // Flow control, manual or negotiated
    manual = !an_en || s.mfc[vpa_pkg::MFC_SEL];
    n.fc_rx = manual ? s.mfc[vpa_pkg::MFC_RX] : s.res_rx & n.port_dup;
    n.fc_tx = manual ? s.mfc[vpa_pkg::MFC_TX] : s.res_tx & n.port_dup;

    // Read data after this cycle's writes, so back to back stays coherent
    n.hrd = 16'h0000;
    if (hsel && hready && htrans[1] && !hwrite && haddr[31:7] == 25'h0000000)
      n.hrd = vpa_rd(n, haddr[6:2]);
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= vpa_pkg::ST_RST;
    else
      s <= n;
  end

  // Outputs
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign hrdata           = {16'h0000, s.hrd};
  assign mdio_value       = mi.mdio_out;
  assign mdio_enable      = mi.mdio_oe;
  assign port_speed_100   = s.port_spd;
  assign port_full_duplex = s.port_dup;
  assign port_rx_pause_en = s.fc_rx;
  assign port_tx_pause_en = s.fc_tx;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  an_order_a: assert property ($rose(s.anc) |-> $past(s.exp[vpa_pkg::EXP_PR]))
    else $error("complete set before page received");

  an_done_a: assert property (
    s.an == vpa_pkg::AN_PAGE && !restart |=> s.an == vpa_pkg::AN_DONE)
    else $error("negotiation did not finish");

  best_mode_a: assert property (
    s.an == vpa_pkg::AN_RESOLVE && common[3] && !restart |=> s.res_spd && s.res_dup)
    else $error("best common mode not chosen");

  pd_fallback_a: assert property (
    s.an == vpa_pkg::AN_RESOLVE && common == 4'h0 && !restart
    |=> !s.res_dup && !s.exp[vpa_pkg::EXP_LPAN] && $onehot(s.lpa[vpa_pkg::TECH_LSB +: 4])
        && s.res_spd == $past(s.pin_st[vpa_pkg::P_SPD]))
    else $error("parallel detect result wrong");

  reset_clear_a: assert property (
    $fell(s.busy) |-> !s.ctrl[vpa_pkg::CTRL_RST] && !s.sr_rc)
    else $error("soft reset bit did not clear");

  hold_result_a: assert property (
    s.an == vpa_pkg::AN_DONE ##1 s.an == vpa_pkg::AN_DONE |-> $stable(s.res_spd)
    && $stable(s.res_dup))
    else $error("result changed without renegotiation");

  forced_mode_a: assert property (
    !s.ctrl[vpa_pkg::CTRL_AN] |=> s.port_spd == $past(s.ctrl[vpa_pkg::CTRL_SPD])
    && s.port_dup == $past(s.ctrl[vpa_pkg::CTRL_DUP]))
    else $error("forced speed or duplex not applied");

  mac_duplex_a: assert property (
    s.ctrl[vpa_pkg::CTRL_AN] && s.pin_st[vpa_pkg::P_MAC] |=> s.port_dup == $past(dup_match))
    else $error("MAC mode duplex does not follow pin");

  pause_mirror_a: assert property (
    s.an == vpa_pkg::AN_RESOLVE && common != 4'h0 && !restart
    |=> s.lpa[11:10] == $past(s.adv[11:10]))
    else $error("partner pause does not mirror advert");

  mac_silent_a: assert property (
    s.pin_st[vpa_pkg::P_MAC] ##1 s.pin_st[vpa_pkg::P_MAC] |-> !mdio_enable)
    else $error("MDIO driven in MAC mode");

  manual_fc_a: assert property (
    !s.ctrl[vpa_pkg::CTRL_AN] || s.mfc[vpa_pkg::MFC_SEL]
    |=> s.fc_rx == $past(s.mfc[vpa_pkg::MFC_RX]) && s.fc_tx == $past(s.mfc[vpa_pkg::MFC_TX]))
    else $error("manual flow control not applied");

endmodule : vpa_top

// ### verification/vpa_mdio_host.sv
`timescale 1ns/1ps
// Management master; mdc rests low between frames, data line pulled up
module vpa_mdio_host (
  output logic      mdc,
  output logic      mdio_level,
  input  wire logic mdio_value,
  input  wire logic mdio_enable
);
  logic m_oe;
  logic m_bit;
  // Wire level from both drivers, pull-up when released
  assign mdio_level = mdio_enable ? mdio_value : (m_oe ? m_bit : 1'b1);
  initial
  begin
    mdc = 1'b0;
    m_oe = 1'b0;
    m_bit = 1'b1;
  end
  // One bit: set while low, sample just before the rise
  task automatic tick(input logic d, input logic oe, output logic s);
    m_bit = d;
    m_oe = oe;
    #32 s = mdio_level;
    mdc = 1'b1;
    #32 mdc = 1'b0;
  endtask : tick
  // Whole frame, released for turnaround and data on reads
  task automatic frame(input logic rd_op, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [47:0] hdr;
    logic        s;
    hdr = {32'hFFFFFFFF, 2'b01, rd_op, ~rd_op, 5'h00, ra, 2'b10};
    for (int i = 47; i >= 0; i--)
      tick(hdr[i], !(rd_op && i < 2), s);
    for (int i = 15; i >= 0; i--)
    begin
      tick(wd[i], !rd_op, s);
      rd[i] = s;
    end
    tick(1'b1, 1'b0, s);
  endtask : frame
endmodule : vpa_mdio_host

// ### verification/test_virtual_phy_autoneg.sv
`timescale 1ns/1ps
module test_virtual_phy_autoneg;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, hr_q;
  logic [1:0]  htrans;
  logic        mdc, mdio_level, mdio_value, mdio_enable;
  logic        dup_pin, pol, spd, mac, dsr, eer;
  logic [3:0]  port;
  logic [15:0] v;
  int          fail_count;
  int          cmp_count;
  vpa_top #(.RCTL_RST_CYC(16'h0014)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mdc(mdc), .mdio_level(mdio_level),
    .mdio_value(mdio_value), .mdio_enable(mdio_enable), .port0_duplex_pin(dup_pin),
    .duplex_polarity_strap(pol), .speed_default_strap(spd), .mac_mode_pin(mac),
    .digital_soft_reset(dsr), .eeprom_reload(eer), .port_speed_100(port[3]),
    .port_full_duplex(port[2]), .port_rx_pause_en(port[1]), .port_tx_pause_en(port[0]));
  vpa_mdio_host host (.mdc(mdc), .mdio_level(mdio_level), .mdio_value(mdio_value),
                      .mdio_enable(mdio_enable));
  // Clock and read data capture
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) hr_q <= hrdata;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  // Single word transfer, waits on ready in both phases
  task automatic ahb(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    @(negedge hclk);
    rd = hr_q;
    @(posedge hclk);
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 16'h0000, x);
    chk(x, e);
  endtask : rdc
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc(8'h00, 32'h3100);
    rdc(8'h10, 32'h0DE1);
    rdc(8'h04, 32'h782D);
    rdc(8'h18, 32'h0003);
    rdc(8'h14, 32'h0DE1);
    rdc(8'h80, 32'h0000);
    chk({31'h0, hresp}, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_best;
    wr(8'h00, 16'h1200);
    cyc(10);
    chk({28'h0, port}, 32'hF);
    rdc(8'h14, 32'h0DE1);
    $display("test best mode done");
  endtask : t_best
  task automatic t_adv;
    wr(8'h10, 16'h0021);
    dup_pin <= 1'b1;
    cyc(10);
    chk({28'h0, port}, 32'hF);
    eer <= 1'b1;
    cyc(1);
    eer <= 1'b0;
    cyc(10);
    chk({28'h0, port}, 32'h0);
    rdc(8'h14, 32'h00A1);
    $display("test advertise done");
  endtask : t_adv
  task automatic t_pd;
    wr(8'h10, 16'h0101);
    dsr <= 1'b1;
    cyc(1);
    dsr <= 1'b0;
    cyc(10);
    chk({28'h0, port}, 32'h8);
    rdc(8'h14, 32'h0081);
    rdc(8'h18, 32'h0002);
    $display("test parallel detect done");
  endtask : t_pd
  task automatic t_manual;
    wr(8'h00, 16'h0000);
    wr(8'h00, 16'h2100);
    cyc(4);
    chk({28'h0, port}, 32'hC);
    wr(8'h40, 16'h0003);
    cyc(4);
    chk({28'h0, port}, 32'hF);
    rdc(8'h40, 32'h003B);
    rdc(8'h10, 32'h0101);
    $display("test manual done");
  endtask : t_manual
  task automatic t_mac;
    wr(8'h40, 16'h0007);
    mac <= 1'b1;
    wr(8'h00, 16'h1000);
    cyc(10);
    chk({28'h0, port}, 32'hB);
    dup_pin <= 1'b0;
    cyc(10);
    chk({28'h0, port}, 32'hF);
    host.frame(1'b1, 5'h00, 16'h0000, v);
    chk({16'h0, v}, 32'hFFFF);
    mac <= 1'b0;
    cyc(10);
    host.frame(1'b1, 5'h00, 16'h0000, v);
    chk({16'h0, v}, 32'h1000);
    host.frame(1'b0, 5'h04, 16'h0DE1, v);
    cyc(10);
    rdc(8'h10, 32'h0DE1);
    $display("test mac mode done");
  endtask : t_mac
  task automatic t_srst;
    wr(8'h00, 16'h8000);
    rdc(8'h00, 32'hB100);
    cyc(30);
    rdc(8'h00, 32'h3100);
    wr(8'h44, 16'h0002);
    rdc(8'h44, 32'h0002);
    cyc(40);
    rdc(8'h44, 32'h0000);
    $display("test soft reset done");
  endtask : t_srst
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {hresetn, hsel, hwrite, dsr, eer, mac, dup_pin, pol} = '0;
    {haddr, hwdata, htrans} = '0;
    spd = 1'b1;
    fail_count = 0;
    cmp_count = 0;
    cyc(20);
    hresetn <= 1'b1;
    cyc(20);
    t_reset;
    t_best;
    t_adv;
    t_pd;
    t_manual;
    t_mac;
    t_srst;
    conclude;
  end
  // Watchdog
  initial
  begin
    cyc(25000);
    fail_count++;
    conclude;
  end
endmodule : test_virtual_phy_autoneg
